//--- adc_pkg.sv
// package: constants and types of the amplifier control byte interface
package adc_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h6C;
  localparam int         NUM_CH        = 4;
  localparam int         CHAN_BITS     = 6;
  localparam int         NUM_DIAG      = 4;
  // control byte one fields
  localparam int         C1_TIMING     = 7;
  localparam int         C1_DIAG_EN    = 6;
  localparam int         C1_OFS_EN     = 5;
  localparam int         C1_GAIN_FRONT = 4;
  localparam int         C1_GAIN_REAR  = 3;
  localparam int         C1_PLAY_FRONT = 2;
  localparam int         C1_PLAY_REAR  = 1;
  localparam int         C1_CLIP_THR   = 0;
  // control byte two fields
  localparam int         C2_CUR_THR    = 7;
  localparam int         C2_FAST_MUTE  = 6;
  localparam int         C2_FLAG_SEL   = 5;
  localparam int         C2_PLAY       = 4;
  localparam int         C2_LINE_MODE  = 3;
  localparam int         C2_CUR_EN     = 2;
  localparam int         C2_LOWQ_FRONT = 1;
  localparam int         C2_LOWQ_REAR  = 0;
  // channel byte fields
  localparam int         CH_SHORT_GND  = 0;
  localparam int         CH_SHORT_VCC  = 1;
  localparam int         CH_OPEN_OFS   = 2;
  localparam int         CH_SHORT_LOAD = 3;
  localparam int         CH_PERMANENT  = 4;
  localparam int         CH_CUR_OPEN   = 5;
  localparam int         SUB_AUTOINC   = 7;
  localparam logic [7:0] CTRL1_RST     = 8'h00;
  localparam logic [7:0] CTRL2_RST     = 8'h00;

  typedef enum logic [2:0] {
    ADC_IDLE  = 3'b000,
    ADC_ADDR  = 3'b001,
    ADC_SUB   = 3'b011,
    ADC_WDATA = 3'b010,
    ADC_RDATA = 3'b110,
    ADC_RACK  = 3'b111,
    ADC_WAIT  = 3'b101
  } adc_state_e;

  typedef struct packed {
    logic       thermal_warn;
    logic       diag_done;
    logic [3:0] short_gnd;
    logic [3:0] short_vcc;
    logic [3:0] open_ofs;
    logic [3:0] short_load;
    logic [3:0] permanent;
    logic [3:0] cur_open;
  } adc_diag_s;

  typedef struct packed {
    logic diag_en;
    logic ofs_en;
    logic gain12_front;
    logic gain12_rear;
    logic play_front;
    logic play_rear;
    logic clip10;
    logic turnon_normal;
    logic cur_thr_300;
    logic fast_mute;
    logic flag_offset;
    logic play;
    logic line_mode;
    logic cur_en;
    logic lowq_front;
    logic lowq_rear;
  } adc_ctrl_s;
endpackage

//--- adc_ctrl.sv
// amplifier control and diagnostic byte slave on a two-wire serial bus
// Summary of operation
// - answer only slave address 1101100
// - direction bit zero writes, one reads
// - control one bit 6 enables diagnostic cycle
// - control one bit 5 enables offset detection
// - bits 4/3 pick front/rear gain 26/12dB
// - bits 2/1 unmute front/rear, zero mutes
// - control two bit 7 picks current threshold
// - control two bit 6 switches fast mute
// - control two bit 5 routes clip/offset flag
// - control two bit 4 leaves standby
// - control two bit 3 picks line-driver diagnostics
// - control two bit 2 enables current detection
// - control two bits 1/0 pick low quiescent
// - read returns four diagnostic bytes in order
// - byte one: thermal warning, cycle terminated
// - byte two: offset and current sensor active
// - channel bits 0,1,3 report short faults
// - channel bit 4 marks permanent diagnosis
// - channel bit 2 open load or offset
// - channel bit 5 current open, when enabled
// - byte three mirrors standby and diag enable
// - sub-address top bit selects auto-increment
module adc_ctrl (
  input  wire logic               mclk_i,
  input  wire logic               arst_n_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_o,
  input  wire adc_pkg::adc_diag_s diag_i,
  input  wire logic               clip_det_i,
  input  wire logic               ofs_det_i,
  output adc_pkg::adc_ctrl_s      ctrl_o,
  output logic                    diag_cycle_o,
  output logic                    shared_flag_output_o
);

  // ****************************************************************
  // reset and input synchronisers
  // ****************************************************************
  logic       rst_m_q, rst_n_q;
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_d_q, sda_d_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // only the second stage and its one-cycle delayed copy are looked at by the edge logic
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = scl_s_q[1];
  assign sda      = sda_s_q[1];
  assign scl_rise = scl & ~scl_d_q;
  assign scl_fall = ~scl & scl_d_q;
  assign start_c  = scl & scl_d_q & sda_d_q & ~sda;
  assign stop_c   = scl & scl_d_q & ~sda_d_q & sda;

  // ****************************************************************
  // bus state machine
  // ****************************************************************
  adc_pkg::adc_state_e state_q;
  logic [3:0]          bit_q;
  logic [7:0]          shift_q;
  logic                ack_q;
  logic                autoinc_q;
  logic                ptr_q;
  logic [1:0]          rd_idx_q;
  logic [7:0]          ctrl1_q, ctrl2_q;
  logic [7:0]          tx_q;
  logic                sda_o_q, sda_oe_q;
  logic                byte_done;
  logic [7:0]          rx_byte;

  assign byte_done = scl_rise && (bit_q == 4'd7);
  assign rx_byte   = {shift_q[6:0], sda};

  // assemble the four diagnostic bytes, one per channel
  logic [7:0] dbyte [adc_pkg::NUM_DIAG];
  genvar g;
  generate
    for (g = 0; g < adc_pkg::NUM_CH; g++) begin : g_ch
      logic [7:0] low;
      assign low = {2'b00,
        diag_i.cur_open[g] & ctrl2_q[adc_pkg::C2_CUR_EN],
        diag_i.permanent[g],
        diag_i.short_load[g],
        diag_i.open_ofs[g],
        diag_i.short_vcc[g],
        diag_i.short_gnd[g]};
      if (g == 0) begin : g_b1
        assign dbyte[g] = low | {diag_i.thermal_warn, diag_i.diag_done, 6'h00};
      end else if (g == 1) begin : g_b2
        assign dbyte[g] = low | {ctrl1_q[adc_pkg::C1_OFS_EN],
                                 ctrl2_q[adc_pkg::C2_CUR_EN], 6'h00};
      end else if (g == 2) begin : g_b3
        assign dbyte[g] = low | {ctrl2_q[adc_pkg::C2_PLAY],
                                 ctrl1_q[adc_pkg::C1_DIAG_EN], 6'h00};
      end else begin : g_b4
        assign dbyte[g] = low;
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q   <= adc_pkg::ADC_IDLE;
      bit_q     <= 4'd0;
      shift_q   <= 8'h00;
      ack_q     <= 1'b0;
      autoinc_q <= 1'b0;
      ptr_q     <= 1'b0;
      rd_idx_q  <= 2'd0;
      ctrl1_q   <= adc_pkg::CTRL1_RST;
      ctrl2_q   <= adc_pkg::CTRL2_RST;
      tx_q      <= 8'h00;
    end else if (start_c) begin
      state_q <= adc_pkg::ADC_ADDR;
      bit_q   <= 4'd0;
      ack_q   <= 1'b0;
    end else if (stop_c) begin
      state_q <= adc_pkg::ADC_IDLE;
      ack_q   <= 1'b0;
    end else begin
      if (scl_rise && bit_q < 4'd8) begin
        shift_q <= rx_byte;
        bit_q   <= bit_q + 4'd1;
      end
      // acknowledge slot ends on falling edge after ninth clock
      if (scl_fall && bit_q == 4'd9) begin
        bit_q <= 4'd0;
        ack_q <= 1'b0;
      end
      if (scl_fall && bit_q == 4'd8) begin
        bit_q <= 4'd9;
      end
      case (state_q)
        adc_pkg::ADC_ADDR: begin
          if (byte_done) begin
            if (rx_byte[7:1] == adc_pkg::DEV_ADDR) begin
              ack_q    <= 1'b1;
              rd_idx_q <= 2'd0;
              state_q  <= rx_byte[0] ? adc_pkg::ADC_RDATA : adc_pkg::ADC_SUB;
              tx_q     <= dbyte[0];
            end else begin
              state_q  <= adc_pkg::ADC_WAIT;
            end
          end
        end
        adc_pkg::ADC_SUB: begin
          if (byte_done) begin
            ack_q     <= 1'b1;
            autoinc_q <= rx_byte[adc_pkg::SUB_AUTOINC];
            ptr_q     <= rx_byte[0];
            state_q   <= adc_pkg::ADC_WDATA;
          end
        end
        adc_pkg::ADC_WDATA: begin
          if (byte_done) begin
            ack_q <= 1'b1;
            if (!ptr_q) begin
              ctrl1_q <= rx_byte;
            end else begin
              ctrl2_q <= rx_byte;
            end
            if (autoinc_q) begin
              ptr_q <= ~ptr_q;
            end
          end
        end
        adc_pkg::ADC_RDATA: begin
          // master acknowledge sampled on ninth rising edge; the ninth
          // clock of the address byte carries our own ack and is skipped
          if (scl_rise && bit_q == 4'd9 && !ack_q) begin
            if (sda) begin
              state_q <= adc_pkg::ADC_WAIT;
            end else begin
              rd_idx_q <= rd_idx_q + 2'd1;
              tx_q     <= dbyte[2'(rd_idx_q + 2'd1)];
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // data line drive, changed while the clock is low, and released on a start or stop
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sda_o_q  <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (start_c || stop_c) begin
      sda_oe_q <= 1'b0;
    end else if (!scl) begin
      sda_o_q  <= 1'b0;
      // bit_q moves to 9 on the eighth fall, so both counts keep the
      // acknowledge low through the whole ninth clock
      if (ack_q && (bit_q == 4'd8 || bit_q == 4'd9)) begin
        sda_oe_q <= 1'b1;
      end else if (state_q == adc_pkg::ADC_RDATA && bit_q < 4'd8 &&
                   !(bit_q == 4'd0 && ack_q)) begin
        // open drain: enable only to pull a zero
        sda_oe_q <= ~tx_q[3'(4'd7 - bit_q)];
      end else begin
        sda_oe_q <= 1'b0;
      end
    end
  end
  assign sda_o    = sda_o_q;
  assign sda_oe_o = sda_oe_q;

  // ****************************************************************
  // amplifier control outputs
  // ****************************************************************
  adc_pkg::adc_ctrl_s ctrl_q;
  logic               flag_q;

  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= '0;
      flag_q <= 1'b0;
    end else begin
      ctrl_q.turnon_normal <= ctrl1_q[adc_pkg::C1_TIMING];
      ctrl_q.diag_en       <= ctrl1_q[adc_pkg::C1_DIAG_EN];
      ctrl_q.ofs_en        <= ctrl1_q[adc_pkg::C1_OFS_EN];
      ctrl_q.gain12_front  <= ctrl1_q[adc_pkg::C1_GAIN_FRONT];
      ctrl_q.gain12_rear   <= ctrl1_q[adc_pkg::C1_GAIN_REAR];
      ctrl_q.play_front    <= ctrl1_q[adc_pkg::C1_PLAY_FRONT];
      ctrl_q.play_rear     <= ctrl1_q[adc_pkg::C1_PLAY_REAR];
      ctrl_q.clip10        <= ctrl1_q[adc_pkg::C1_CLIP_THR];
      ctrl_q.cur_thr_300   <= ctrl2_q[adc_pkg::C2_CUR_THR];
      ctrl_q.fast_mute     <= ctrl2_q[adc_pkg::C2_FAST_MUTE];
      ctrl_q.flag_offset   <= ctrl2_q[adc_pkg::C2_FLAG_SEL];
      ctrl_q.play          <= ctrl2_q[adc_pkg::C2_PLAY];
      ctrl_q.line_mode     <= ctrl2_q[adc_pkg::C2_LINE_MODE];
      ctrl_q.cur_en        <= ctrl2_q[adc_pkg::C2_CUR_EN];
      ctrl_q.lowq_front    <= ctrl2_q[adc_pkg::C2_LOWQ_FRONT];
      ctrl_q.lowq_rear     <= ctrl2_q[adc_pkg::C2_LOWQ_REAR];
      // detector inputs are same-clock logic, no synchroniser
      flag_q <= ctrl2_q[adc_pkg::C2_FLAG_SEL] ? ofs_det_i
                                              : clip_det_i;
    end
  end
  assign ctrl_o               = ctrl_q;
  assign diag_cycle_o         = ctrl_q.diag_en;
  assign shared_flag_output_o = flag_q;

endmodule // adc_ctrl

//--- adc_ctrl_monitor.sv
// checker: pin timing relations of the control byte slave
module adc_ctrl_monitor (
  input wire logic               mclk_i,
  input wire logic               arst_n_i,
  input wire logic               scl_i,
  input wire logic               sda_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_o,
  input wire adc_pkg::adc_diag_s diag_i,
  input wire logic               clip_det_i,
  input wire logic               ofs_det_i,
  input wire adc_pkg::adc_ctrl_s ctrl_o,
  input wire logic               diag_cycle_o,
  input wire logic               shared_flag_output_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] hi_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // a zero read byte plus the address ack is the longest legal pull
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) hi_q <= 7'h00;
    else hi_q <= sda_oe_o ? hi_q + 7'h01 : 7'h00;
  end
  sequence bus_idle;
    scl_i [*8];
  endsequence
  diag_mirror_a: assert property (diag_cycle_o == ctrl_o.diag_en ||
    diag_cycle_o == $past(ctrl_o.diag_en)) else $error("diag copy wrong");
  flag_clip_a: assert property (
    !ctrl_o.flag_offset && !$past(ctrl_o.flag_offset, 2) |->
    shared_flag_output_o == $past(clip_det_i)) else $error("clip flag");
  flag_ofs_a: assert property (
    ctrl_o.flag_offset && $past(ctrl_o.flag_offset, 2) |->
    shared_flag_output_o == $past(ofs_det_i)) else $error("offset flag");
  open_drain_a: assert property (sda_oe_o |-> !sda_o)
    else $error("data driven high");
  data_hold_a: assert property ($rose(scl_i) |->
    ##2 $stable(sda_oe_o) [*3]) else $error("data moved in clock high");
  pull_bound_a: assert property (hi_q <= 7'h50)
    else $error("data line held too long");
  ctrl_update_a: assert property ($changed(ctrl_o) |-> !sda_oe_o)
    else $error("control changed during ack");
  ctrl_idle_a: assert property (bus_idle |-> $stable(ctrl_o))
    else $error("control changed on idle bus");
  idle_release_a: assert property (bus_idle |-> !sda_oe_o)
    else $error("data held on idle bus");
endmodule // adc_ctrl_monitor

//--- adc_host_model.sv
// partner: bus master that writes control and reads diagnostic bytes
module adc_host_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // data moves one cycle after the fall so it never races the clock edge
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk_i);
    sda_oe_o <= !b;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start();
    @(posedge clk_i);
    sda_oe_o <= 1'b0;
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b1;
    half();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clk_i);
    sda_oe_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ak);
  endtask
endmodule // adc_host_model

//--- adc_ctrl_bench.sv
// testbench: host transfers against the control byte slave
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end end
module adc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk_i = 1'b0, arst_n_i = 1'b0;
  logic               clip_det_i = 1'b0, ofs_det_i = 1'b0;
  adc_pkg::adc_diag_s diag_i = '0;
  adc_pkg::adc_ctrl_s ctrl_o;
  logic               scl, host_oe, sda_o, sda_oe_o, diag_cycle_o, flag;
  logic [7:0]         q, c1, c2;
  logic               ak;
  int                 err_count = 0, check_count = 0, cyc = 0;
  wire                sda = !(host_oe || (sda_oe_o && !sda_o));
  adc_host_model h (.clk_i(mclk_i), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(host_oe));
  adc_ctrl uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .diag_i(diag_i),
    .clip_det_i(clip_det_i), .ofs_det_i(ofs_det_i), .ctrl_o(ctrl_o),
    .diag_cycle_o(diag_cycle_o), .shared_flag_output_o(flag));
  always #20 mclk_i = ~mclk_i;
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  function automatic logic [7:0] exp_db(int i);
    logic [1:0] t;
    t = i == 0 ? {diag_i.thermal_warn, diag_i.diag_done} :
        i == 1 ? {c1[5], c2[2]} : i == 2 ? {c2[4], c1[6]} : 2'b00;
    return {t, diag_i.cur_open[i] & c2[2], diag_i.permanent[i],
      diag_i.short_load[i], diag_i.open_ofs[i], diag_i.short_vcc[i],
      diag_i.short_gnd[i]};
  endfunction
  task automatic wr(input logic [7:0] sub, d0, d1, input logic two);
    h.start();
    h.xfer(8'hD8, 1'b1, q, ak);
    `CHK(ak, 1'b0)
    h.xfer(sub, 1'b1, q, ak);
    h.xfer(d0, 1'b1, q, ak);
    if (two) h.xfer(d1, 1'b1, q, ak);
    `CHK(ak, 1'b0)
    h.stop();
  endtask
  task automatic rd();
    h.start();
    h.xfer(8'hD9, 1'b1, q, ak);
    `CHK(ak, 1'b0)
    for (int i = 0; i < 4; i++) begin
      h.xfer(8'hFF, i == 3, q, ak);
      `CHK(q, exp_db(i))
    end
    h.stop();
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    c1 = 8'h00;
    c2 = 8'h00;
    `CHK(ctrl_o, 16'h0000)
    // ********************
    // foreign addresses
    // ********************
    for (int k = 0; k < 3; k++) begin
      h.start();
      h.xfer(k == 0 ? 8'hDA : k == 1 ? 8'h58 : 8'hD0, 1'b1, q, ak);
      `CHK(ak, 1'b1)
      h.stop();
    end
    // ********************
    // every control bit both ways, then reads
    // ********************
    for (int k = 0; k < 2; k++) begin
      c1 = k ? 8'h55 : 8'hAA;
      c2 = ~c1;
      // sub-address bit 0 clear: first control byte, then the second
      wr(8'h80, c1, c2, 1'b1);
      `CHK(ctrl_o, {c1[6:0], c1[7], c2})
      `CHK(diag_cycle_o, c1[6])
      diag_i <= k ? 26'h2AAAAAA : 26'h1555555;
      @(posedge mclk_i);
      repeat (2) rd();
    end
    // ********************
    // single byte and rewrite without increment
    // ********************
    wr(8'h01, 8'h3C, 8'h00, 1'b0);
    c2 = 8'h3C;
    `CHK(ctrl_o, {c1[6:0], c1[7], c2})
    wr(8'h00, 8'h11, 8'h22, 1'b1);
    c1 = 8'h22;
    `CHK(ctrl_o, {c1[6:0], c1[7], c2})
    rd();
    // ********************
    // shared flag routing
    // ********************
    ofs_det_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    `CHK(flag, 1'b1)
    wr(8'h01, 8'h1C, 8'h00, 1'b0);
    `CHK(flag, 1'b0)
    clip_det_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    `CHK(flag, 1'b1)
    conclude();
  end
endmodule // adc_ctrl_bench
bind adc_ctrl adc_ctrl_monitor mon (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .diag_i(diag_i), .clip_det_i(clip_det_i), .ofs_det_i(ofs_det_i),
  .ctrl_o(ctrl_o), .diag_cycle_o(diag_cycle_o),
  .shared_flag_output_o(shared_flag_output_o));
